// ### rtl/ssse_exec.sv
// Notes on behaviour
// - minus_to_memory: W minus byte, into memory, flags
// - borrow_inverse_bit 0 if negative, else 1
// - minus_immediate: W minus immediate, into W, flags
// - Nibble exchange in place, flags untouched
// - Exchanged byte into W, memory and flags untouched
// - Skip next when byte is zero, no flags
// - Copy byte to W, skip if zero
// - Bit form skips when selected bit zero
// - Every conditional skip takes two cycles
// - No skip: continue with following instruction
//
// Register access over APB and the placing of the registers were decided locally.
module ssse_exec #(
  parameter int MEM_DEPTH = 64
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction issue from the decoder
  input wire logic instValid,
  input wire ssse_pkg::ssse_inst_type inst,
  output logic instReady,
  // Completion towards the program counter logic
  output logic doneQ,
  output logic skipNextQ,
  output logic [7:0] workingRegister,
  output ssse_pkg::ssse_flags_type flagsOut
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  typedef enum {
    EXEC_IDLE,
    EXEC_DUMMY
  } ssse_state_type;

  logic [7:0] dataMem [MEM_DEPTH];     // Data memory bytes
  logic [7:0] wreg_q;                  // Working register
  logic [7:0] wreg_d;
  ssse_pkg::ssse_flags_type flags_q;   // Arithmetic flags
  ssse_pkg::ssse_flags_type flags_d;
  ssse_state_type state_q;             // Pipeline state
  ssse_state_type state_d;
  logic run_q;                         // Accept instructions
  logic done_q;                        // Completion pulse
  logic done_d;
  logic skip_q;                        // Discard next fetched word
  logic skip_d;
  logic lastSkip_q;                    // Sticky record of last skip
  logic [7:0] count_q;                 // Executed instruction count
  logic [31:0] prdata_q;               // Registered read data
  logic pslverr_q;

  // APB decode nets, declared early as the next-state logic reads them
  localparam int ADDR_W_L = ssse_pkg::ADDR_W;
  wire logic apbAcc;                   // Access phase, always ready
  wire logic apbWr;
  wire logic hitCtrl;
  wire logic hitW;
  wire logic hitF;
  wire logic hitStat;
  wire logic hitMem;
  wire logic hitAny;
  wire logic apbWrW;
  wire logic apbWrF;
  wire logic apbWrCtrl;
  wire logic apbWrMem;
  wire logic [11:0] memOfs;
  wire logic [ADDR_W_L-1:0] apbMemIdx;
  wire logic [31:0] statWord;
  wire logic [31:0] readMux;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  wire logic issue;                    // Instruction taken this edge
  wire logic [7:0] memByte;            // Addressed byte
  wire logic [7:0] subtrahend;         // Memory byte or immediate
  wire logic [8:0] diffWide;           // Ninth bit is the borrow
  wire logic [4:0] lowWide;            // Low nibble with borrow
  wire logic [7:0] diff;
  wire logic [7:0] swapped;            // Nibble exchanged byte
  wire logic isSubMem;
  wire logic isSubImm;
  wire logic isSub;
  wire logic isSwapMem;
  wire logic isSwapW;
  wire logic isSkipByte;
  wire logic isCopySkip;
  wire logic isSkipBit;
  wire logic isSkip;
  wire logic memAddrOk;                // Address inside the array
  wire logic skipCond;
  wire logic memWrite;                 // Execution writes memory
  wire logic [7:0] memWdata;
  wire ssse_pkg::ssse_flags_type subFlags;

  // Busy during the dummy cycle or while halted by software
  assign instReady = run_q && (state_q == EXEC_IDLE);
  assign issue = instValid && instReady;

  assign isSubMem = inst.op == ssse_pkg::MINUS_TO_MEMORY;
  assign isSubImm = inst.op == ssse_pkg::MINUS_IMMEDIATE;
  assign isSub = isSubMem || isSubImm;
  assign isSwapMem = inst.op == ssse_pkg::NIBBLE_EXCHANGE_IN_PLACE;
  assign isSwapW = inst.op == ssse_pkg::NIBBLE_EXCHANGE_TO_WORKING;
  assign isSkipByte = inst.op == ssse_pkg::SKIP_ON_NULL_BYTE;
  assign isCopySkip = inst.op == ssse_pkg::COPY_THEN_SKIP_ON_NULL;
  assign isSkipBit = inst.op == ssse_pkg::SKIP_ON_NULL_BIT;
  assign isSkip = isSkipByte || isCopySkip || isSkipBit;

  // Out-of-range addresses read as zero and are never written
  assign memAddrOk = 32'(inst.addr) < MEM_DEPTH;
  assign memByte = memAddrOk ? dataMem[inst.addr] : 8'h00;

  // ----------------------------------------------------------------
  // Subtractor
  // ----------------------------------------------------------------
  // Immediate comes from the instruction word, otherwise memory
  assign subtrahend = isSubImm ? inst.imm : memByte;
  assign diffWide = {1'b0, wreg_q} - {1'b0, subtrahend};
  assign lowWide = {1'b0, wreg_q[3:0]} - {1'b0, subtrahend[3:0]};
  assign diff = diffWide[7:0];

  // Unsigned borrow out means a negative difference
  assign subFlags.borrowInverse = ~diffWide[8];
  assign subFlags.nibbleBorrow = ~lowWide[4];
  assign subFlags.resultNull = diff == 8'h00;
  // Signed overflow: operands differ in sign, result sign flips
  assign subFlags.signedWrap = (wreg_q[7] ^ subtrahend[7])
                               && (diff[7] ^ wreg_q[7]);

  // ----------------------------------------------------------------
  // Exchange and skip tests
  // ----------------------------------------------------------------
  assign swapped = {memByte[3:0], memByte[7:4]};
  // Byte forms test the whole byte, bit form one selected bit
  assign skipCond = isSkipBit ? ~memByte[inst.bitSel]
                              : (memByte == 8'h00);

  // Only the two write-back forms touch memory
  assign memWrite = issue && memAddrOk && (isSubMem || isSwapMem);
  assign memWdata = isSubMem ? diff : swapped;

  // ----------------------------------------------------------------
  // Next state of working register, flags and pipeline
  // ----------------------------------------------------------------
  // APB writes to W and flags yield to an instruction in the same
  // cycle; software is expected to halt the core before editing.
  always_comb
  begin
    wreg_d = wreg_q;
    flags_d = flags_q;
    state_d = state_q;
    done_d = 1'b0;
    skip_d = 1'b0;
    case (state_q)
      EXEC_IDLE:
      begin
        if (issue)
        begin
          if (isSub)
          begin
            flags_d = subFlags;
          end
          if (isSubImm)
          begin
            wreg_d = diff;
          end
          else if (isSwapW)
          begin
            wreg_d = swapped;
          end
          else if (isCopySkip)
          begin
            wreg_d = memByte;
          end
          if (isSkip)
          begin
            // Second cycle is the dummy slot while the next word
            // is fetched, whether or not the skip is taken
            state_d = EXEC_DUMMY;
            skip_d = skipCond;
          end
          else
          begin
            done_d = 1'b1;
          end
        end
        else if (apbWrW)
        begin
          wreg_d = pwdata[7:0];
        end
        else if (apbWrF)
        begin
          flags_d = pwdata[3:0];
        end
      end
      EXEC_DUMMY:
      begin
        // Skip verdict is held through the dummy cycle
        skip_d = skip_q;
        done_d = 1'b1;
        state_d = EXEC_IDLE;
        if (apbWrW)
        begin
          wreg_d = pwdata[7:0];
        end
        else if (apbWrF)
        begin
          flags_d = pwdata[3:0];
        end
      end
      default:
      begin
        state_d = EXEC_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign apbAcc = psel && penable;
  assign apbWr = apbAcc && pwrite;
  assign memOfs = paddr - ssse_pkg::MEM_BASE;
  assign apbMemIdx = memOfs[ADDR_W_L+1:2];
  assign hitCtrl = paddr == ssse_pkg::CTRL_OFS;
  assign hitW = paddr == ssse_pkg::WREG_OFS;
  assign hitF = paddr == ssse_pkg::FLAG_OFS;
  assign hitStat = paddr == ssse_pkg::STAT_OFS;
  // Word aligned slots only, one byte per word
  assign hitMem = (paddr >= ssse_pkg::MEM_BASE)
                  && (memOfs[1:0] == 2'b00)
                  && (32'(memOfs[11:2]) < MEM_DEPTH);
  assign hitAny = hitCtrl || hitW || hitF || hitStat || hitMem;
  assign apbWrW = apbWr && hitW;
  assign apbWrF = apbWr && hitF;
  assign apbWrCtrl = apbWr && hitCtrl;
  // An instruction write to memory wins the port this cycle
  assign apbWrMem = apbWr && hitMem && !memWrite;

  assign statWord = {16'h0000, count_q, 6'h00, lastSkip_q,
                     (state_q == EXEC_DUMMY)};
  assign readMux = hitCtrl ? {31'h00000000, run_q}
                 : hitW ? {24'h000000, wreg_q}
                 : hitF ? {28'h0000000, flags_q}
                 : hitStat ? statWord
                 : hitMem ? {24'h000000, dataMem[apbMemIdx]}
                 : 32'h00000000;

  // Zero wait states; read data and error registered in the setup cycle
  assign pready = 1'b1;
  assign prdata = prdata_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // Data memory array
  // ----------------------------------------------------------------
  // No reset: memory content is undefined until written
  always_ff @(posedge core_clk)
  begin
    if (memWrite)
    begin
      dataMem[inst.addr] <= memWdata;
    end
    else if (apbWrMem)
    begin
      dataMem[apbMemIdx] <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Core registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wreg_q <= ssse_pkg::WREG_RST;
      flags_q <= ssse_pkg::FLAGS_RST;
      state_q <= EXEC_IDLE;
      done_q <= 1'b0;
      skip_q <= 1'b0;
    end
    else
    begin
      wreg_q <= wreg_d;
      flags_q <= flags_d;
      state_q <= state_d;
      done_q <= done_d;
      skip_q <= skip_d;
    end
  end

  // ----------------------------------------------------------------
  // Status and control
  // ----------------------------------------------------------------
  // Skip record updates when each skip instruction retires
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_q <= ssse_pkg::CTRL_RUN_RST;
      lastSkip_q <= 1'b0;
      count_q <= ssse_pkg::CNT_RST;
    end
    else
    begin
      if (apbWrCtrl)
      begin
        run_q <= pwdata[ssse_pkg::CTRL_RUN_POS];
      end
      if (state_q == EXEC_DUMMY)
      begin
        lastSkip_q <= skip_q;
      end
      if (done_d)
      begin
        count_q <= count_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB read data
  // ----------------------------------------------------------------
  // Registered in the setup cycle so it is stable in access phase
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prdata_q <= 32'h00000000;
      pslverr_q <= 1'b0;
    end
    else
    begin
      prdata_q <= (psel && !penable && !pwrite) ? readMux : prdata_q;
      pslverr_q <= psel && !penable && !hitAny;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign doneQ = done_q;
  assign skipNextQ = skip_q && done_q;
  assign workingRegister = wreg_q;
  assign flagsOut = flags_q;

endmodule

// ### rtl/ssse_pkg.sv
package ssse_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 8;    // Byte datapath
  localparam int ADDR_W = 6;    // Data memory address width
  localparam int APB_AW = 12;   // APB byte address width

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;    // Execution control
  localparam logic [11:0] WREG_OFS = 12'h004;    // Working register
  localparam logic [11:0] FLAG_OFS = 12'h008;    // Arithmetic flags
  localparam logic [11:0] STAT_OFS = 12'h00c;    // Status, read only
  localparam logic [11:0] MEM_BASE = 12'h100;    // Data memory window

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RUN_POS = 0;     // Accept instructions
  localparam int FLAG_BORROW_INV_POS = 0;
  localparam int FLAG_NIBBLE_POS = 1;
  localparam int FLAG_NULL_POS = 2;
  localparam int FLAG_WRAP_POS = 3;
  localparam int STAT_BUSY_POS = 0;    // Dummy cycle in progress
  localparam int STAT_SKIP_POS = 1;    // Last skip was taken
  localparam int STAT_CNT_POS = 8;     // Executed instruction count

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic CTRL_RUN_RST = 1'b1;
  localparam logic [7:0] WREG_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;

  // ----------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------
  localparam int SKIP_CYCLES = 2;      // Conditional skip length
  localparam int PLAIN_CYCLES = 1;     // Subtract and exchange length

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MINUS_TO_MEMORY,
    MINUS_IMMEDIATE,
    NIBBLE_EXCHANGE_IN_PLACE,
    NIBBLE_EXCHANGE_TO_WORKING,
    SKIP_ON_NULL_BYTE,
    COPY_THEN_SKIP_ON_NULL,
    SKIP_ON_NULL_BIT,
    NO_OPERATION
  } ssse_op_type;

  typedef struct packed {
    ssse_op_type op;              // Operation
    logic [ADDR_W-1:0] addr;      // Data memory byte address
    logic [DATA_W-1:0] imm;       // Immediate operand
    logic [2:0] bitSel;           // Bit index for the bit skip
  } ssse_inst_type;

  typedef struct packed {
    logic signedWrap;             // signed_wrap_flag
    logic resultNull;             // result_null_flag
    logic nibbleBorrow;           // nibble_borrow_flag
    logic borrowInverse;          // borrow_inverse_bit
  } ssse_flags_type;

  localparam ssse_flags_type FLAGS_RST = 4'h0;

endpackage

// ### tb/ssse_exec_chk.sv
// Property checker for the execution block, bound from below
module ssse_exec_chk #(
  parameter int MEM_DEPTH = 64
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic instValid,
  input wire ssse_pkg::ssse_inst_type inst,
  input wire logic instReady,
  input wire logic doneQ,
  input wire logic skipNextQ,
  input wire logic [7:0] workingRegister,
  input wire ssse_pkg::ssse_flags_type flagsOut
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----
  // Decode of taken instructions
  // ----
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  logic take; // Instruction accepted this edge
  logic takeSkip; // Any conditional skip
  logic takePlain; // Subtract or exchange
  logic takeImm; // Immediate subtract
  logic takeSwap; // Either nibble exchange
  logic takeCopy; // Copy then skip on zero
  assign takeCopy = take && inst.op == ssse_pkg::COPY_THEN_SKIP_ON_NULL;
  assign take = instValid && instReady;
  assign takeSkip = take && (inst.op inside {ssse_pkg::SKIP_ON_NULL_BYTE,
    ssse_pkg::COPY_THEN_SKIP_ON_NULL, ssse_pkg::SKIP_ON_NULL_BIT});
  assign takePlain = take && !takeSkip && inst.op != ssse_pkg::NO_OPERATION;
  assign takeImm = take && inst.op == ssse_pkg::MINUS_IMMEDIATE;
  assign takeSwap = take && (inst.op == ssse_pkg::NIBBLE_EXCHANGE_IN_PLACE
    || inst.op == ssse_pkg::NIBBLE_EXCHANGE_TO_WORKING);

  // Dummy cycle first, retirement second
  sequence skipRetire;
    (!instReady && !doneQ) ##1 doneQ;
  endsequence

  // ----
  // Assertions
  // ----
  a_skip_two_cycles: assert property (
    takeSkip |=> skipRetire)
    else $error("skip did not retire after one dummy cycle");
  a_plain_one_cycle: assert property (
    takePlain |=> doneQ)
    else $error("plain op did not retire next cycle");
  a_plain_no_dummy: assert property (
    takePlain |=> instReady)
    else $error("dummy cycle after plain op");
  // A skip pulse must follow a dummy cycle, never a plain retirement
  a_skip_with_done: assert property (
    skipNextQ |-> doneQ && $past(!instReady))
    else $error("skip pulse without dummy cycle");
  a_plain_no_skip: assert property (
    takePlain |=> !skipNextQ)
    else $error("plain op asked for a skip");
  a_skip_keeps_flags: assert property (
    takeSkip |=> $stable(flagsOut))
    else $error("skip altered flags");
  a_swap_keeps_flags: assert property (
    takeSwap |=> $stable(flagsOut))
    else $error("nibble exchange altered flags");
  a_imm_result: assert property (
    takeImm |=> workingRegister ==
    $past(workingRegister) - $past(inst.imm))
    else $error("immediate difference wrong");
  a_imm_borrow: assert property (
    takeImm |=> flagsOut.borrowInverse ==
    ($past(workingRegister) >= $past(inst.imm)))
    else $error("borrow bit wrong");
  // Copied byte sits in W during the dummy cycle; skip follows it
  a_copy_skip_zero: assert property (
    takeCopy |=> ##1 (skipNextQ == ($past(workingRegister) == 8'h00)))
    else $error("copy skip verdict wrong");
endmodule

bind ssse_exec ssse_exec_chk #(.MEM_DEPTH(MEM_DEPTH)) uChk (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .instValid(instValid),
  .inst(inst),
  .instReady(instReady),
  .doneQ(doneQ),
  .skipNextQ(skipNextQ),
  .workingRegister(workingRegister),
  .flagsOut(flagsOut)
);

// ### tb/tb_top.sv
`define CHK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin \
  errCount++; $display("[ERR] %s exp %h got %h", nm, e, g); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ----
  // Signals
  // ----
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic instValid = 1'b0;
  ssse_pkg::ssse_inst_type inst = '0;
  logic instReady;
  logic doneQ;
  logic skipNextQ;
  logic [7:0] workingRegister;
  ssse_pkg::ssse_flags_type flagsOut;
  int errCount = 0;
  int totalChecks = 0;
  logic [31:0] rdData; // Last APB read data
  logic rdErr; // Last APB error response
  int lat; // Take-to-retire cycles; 4 means none
  logic skipSeen; // Skip pulse at retirement

  // 25 MHz core clock
  always #20 core_clk = ~core_clk;

  ssse_exec dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .instValid(instValid),
    .inst(inst),
    .instReady(instReady),
    .doneQ(doneQ),
    .skipNextQ(skipNextQ),
    .workingRegister(workingRegister),
    .flagsOut(flagsOut)
  );

  // ----
  // Bus and issue helpers
  // ----
  // One APB transfer; waits on pready, unbounded
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Waits as long as the slave asks; only the watchdog ends it
    do
    begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Offer one instruction, then time its retirement
  task automatic issue(input ssse_pkg::ssse_op_type o, input logic [5:0] a,
                       input logic [7:0] i, input logic [2:0] b);
    @(posedge core_clk);
    instValid <= 1'b1;
    inst <= '{o, a, i, b};
    // Held until taken; only the watchdog ends the wait
    do
    begin
      @(posedge core_clk);
    end while (instReady !== 1'b1);
    instValid <= 1'b0;
    lat = 0;
    while (lat < 4)
    begin
      @(posedge core_clk);
      lat++;
      if (doneQ === 1'b1)
        break;
    end
    skipSeen = skipNextQ;
  endtask

  // Memory byte address in the APB window
  function automatic logic [11:0] ma(input logic [5:0] a);
    return ssse_pkg::MEM_BASE + {4'h0, a, 2'b00};
  endfunction

  // Flags of w - m, worked out independently
  function automatic ssse_pkg::ssse_flags_type subFlags(
    input logic [7:0] w, input logic [7:0] m);
    logic [7:0] r;
    r = w - m;
    return '{(w[7] != m[7]) && (r[7] != w[7]), r == 8'h00,
             w[3:0] >= m[3:0], w >= m};
  endfunction

  // ----
  // Scenarios
  // ----
  // Reset values, then an unmapped address
  task automatic scReset();
    apb(1'b0, ssse_pkg::CTRL_OFS, 32'h0);
    `CHK("ctrl", 32'h1, rdData);
    apb(1'b0, ssse_pkg::WREG_OFS, 32'h0);
    `CHK("wreg", 32'h0, rdData);
    apb(1'b0, ssse_pkg::FLAG_OFS, 32'h0);
    `CHK("flags", 32'h0, rdData);
    apb(1'b0, 12'h050, 32'h0);
    `CHK("slverr", 1'b1, rdErr);
  endtask

  // Positive, negative, overflow and zero differences
  task automatic scSub();
    logic [7:0] w[4] = '{8'h05, 8'h03, 8'h80, 8'h10};
    logic [7:0] m[4] = '{8'h03, 8'h05, 8'h01, 8'h10};
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, ssse_pkg::WREG_OFS, {24'h0, w[k]});
      apb(1'b1, ma(6'(k + 1)), {24'h0, m[k]});
      issue(ssse_pkg::MINUS_TO_MEMORY, 6'(k + 1), 8'h00, 3'h0);
      `CHK("sub lat", 1, lat);
      `CHK("sub flags", subFlags(w[k], m[k]), flagsOut);
      apb(1'b0, ma(6'(k + 1)), 32'h0);
      `CHK("sub mem", {24'h0, w[k] - m[k]}, rdData);
      issue(ssse_pkg::MINUS_IMMEDIATE, 6'h00, m[k], 3'h0);
      `CHK("imm w", w[k] - m[k], workingRegister);
      `CHK("imm flags", subFlags(w[k], m[k]), flagsOut);
    end
  endtask

  // Exchange in place, then into the working register
  task automatic scSwap();
    apb(1'b1, ssse_pkg::FLAG_OFS, 32'ha);
    apb(1'b1, ma(6'h09), 32'h3c);
    issue(ssse_pkg::NIBBLE_EXCHANGE_IN_PLACE, 6'h09, 8'h00, 3'h0);
    apb(1'b0, ma(6'h09), 32'h0);
    `CHK("swap mem", 32'hc3, rdData);
    issue(ssse_pkg::NIBBLE_EXCHANGE_TO_WORKING, 6'h09, 8'h00, 3'h0);
    `CHK("swapw lat", 1, lat);
    `CHK("swapw w", 8'h3c, workingRegister);
    apb(1'b0, ma(6'h09), 32'h0);
    `CHK("swapw mem", 32'hc3, rdData);
    `CHK("swap flags", 4'ha, flagsOut);
  endtask

  // One skip op on a given byte
  task automatic doSkip(input ssse_pkg::ssse_op_type o, input logic [7:0] m,
                        input logic [2:0] b, input logic e);
    apb(1'b1, ma(6'h0c), {24'h0, m});
    issue(o, 6'h0c, 8'h00, b);
    `CHK("skip lat", 2, lat);
    `CHK("skip", e, skipSeen);
  endtask

  // Every skip form, taken and not taken
  task automatic scSkip();
    apb(1'b1, ssse_pkg::FLAG_OFS, 32'h5);
    doSkip(ssse_pkg::SKIP_ON_NULL_BYTE, 8'h00, 3'h0, 1'b1);
    doSkip(ssse_pkg::SKIP_ON_NULL_BYTE, 8'h80, 3'h0, 1'b0);
    doSkip(ssse_pkg::COPY_THEN_SKIP_ON_NULL, 8'h00, 3'h0, 1'b1);
    `CHK("copy w0", 8'h00, workingRegister);
    doSkip(ssse_pkg::COPY_THEN_SKIP_ON_NULL, 8'h5a, 3'h0, 1'b0);
    `CHK("copy w", 8'h5a, workingRegister);
    doSkip(ssse_pkg::SKIP_ON_NULL_BIT, 8'hfb, 3'h2, 1'b1);
    doSkip(ssse_pkg::SKIP_ON_NULL_BIT, 8'h04, 3'h2, 1'b0);
    `CHK("skip flags", 4'h5, flagsOut);
  endtask

  // Two subtracts on consecutive edges, no gap
  task automatic scBack();
    apb(1'b1, ssse_pkg::WREG_OFS, 32'h20);
    @(posedge core_clk);
    instValid <= 1'b1;
    inst <= '{ssse_pkg::MINUS_IMMEDIATE, 6'h00, 8'h01, 3'h0};
    @(posedge core_clk);
    inst <= '{ssse_pkg::MINUS_IMMEDIATE, 6'h00, 8'h02, 3'h0};
    @(posedge core_clk);
    `CHK("b2b ready", 1'b1, instReady);
    instValid <= 1'b0;
    @(posedge core_clk);
    `CHK("b2b w", 8'h1d, workingRegister);
  endtask

  // ----
  // Run control
  // ----
  task automatic finishTest();
    $display("checks %0d errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence after 8 cycles of reset
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    scReset();
    scSub();
    scSwap();
    scSkip();
    scBack();
    finishTest();
  end

  // Whole run needs well under 1000 cycles
  initial
  begin
    repeat (5000) @(posedge core_clk);
    errCount++;
    finishTest();
  end
endmodule
